// ==== core/aefu_pkg.sv ====
// Package for the access error frame unit: frame layout, field positions, codes.
// Assumes a single core clock domain and a classic Wishbone register port.
package aefu_pkg;

  // ==========================================================================
  // Frame geometry
  localparam int unsigned AEFU_FRAME_WORDS  = 30;
  localparam int unsigned AEFU_FRAME_BYTES  = 60;
  localparam int unsigned AEFU_SHORT_BYTES  = 12;
  localparam logic [3:0]  AEFU_FMT_ACCESS   = 4'h7;
  localparam logic [3:0]  AEFU_FMT_SHORT    = 4'h2;
  localparam logic [3:0]  AEFU_FMT_NORMAL   = 4'h0;

  // ==========================================================================
  // Status halfword bit positions
  localparam int unsigned AEFU_SSW_CT   = 13;
  localparam int unsigned AEFU_SSW_CM   = 12;
  localparam int unsigned AEFU_SSW_MIS  = 11;
  localparam int unsigned AEFU_SSW_PRIV = 10;
  localparam int unsigned AEFU_SSW_LOCK = 9;
  localparam int unsigned AEFU_SSW_RD   = 8;
  localparam int unsigned AEFU_SSW_SZ   = 5;
  localparam int unsigned AEFU_SSW_KIND = 3;
  localparam int unsigned AEFU_SSW_MOD  = 0;

  // Write-back status layout: valid bit 7, size 6:5, kind 4:3, modifier 2:0.
  localparam int unsigned AEFU_WBS_V = 7;

  // Modifier, kind and size codes.
  localparam logic [2:0] AEFU_TM_PUSH  = 3'h0;
  localparam logic [2:0] AEFU_TM_UDATA = 3'h1;
  localparam logic [2:0] AEFU_TM_UCODE = 3'h2;
  localparam logic [2:0] AEFU_TM_SDATA = 3'h5;
  localparam logic [2:0] AEFU_TM_SCODE = 3'h6;
  localparam logic [1:0] AEFU_TT_NORM  = 2'h0;
  localparam logic [1:0] AEFU_TT_LINE  = 2'h1;
  localparam logic [1:0] AEFU_SZ_LONG  = 2'h0;
  localparam logic [1:0] AEFU_SZ_BYTE  = 2'h1;
  localparam logic [1:0] AEFU_SZ_WORD  = 2'h2;
  localparam logic [1:0] AEFU_SZ_LINE  = 2'h3;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] AEFU_R_CTRL   = 8'h00;
  localparam logic [7:0] AEFU_R_STAT   = 8'h04;
  localparam logic [7:0] AEFU_R_SSW    = 8'h08;
  localparam logic [7:0] AEFU_R_ELOC   = 8'h0c;
  localparam logic [7:0] AEFU_R_WBS    = 8'h10;
  localparam logic [7:0] AEFU_R_RSSW   = 8'h14;
  localparam logic [7:0] AEFU_R_RFMT   = 8'h18;
  localparam logic [7:0] AEFU_R_RES    = 8'h1c;
  localparam logic [7:0] AEFU_R_SLOTA  = 8'h20;  // 0x20..0x34: wb3a,writeback_three_payload,wb2a,writeback_two_payload,wb1a,writeback_one_payload
  localparam logic [7:0] AEFU_R_PUSH   = 8'h38;  // 0x38..0x44: push image 0..3
  localparam logic [31:0] AEFU_UNMAPPED = 32'h0000_0000;

  // Return outcomes reported in the status register.
  typedef enum logic [2:0] {
    AEFU_RET_NONE,
    AEFU_RET_RESUME,
    AEFU_RET_MMOVE,
    AEFU_RET_PEND,
    AEFU_RET_FMTX,
    AEFU_RET_NEST,
    AEFU_RET_MULTI
  } aefu_ret_t;

  // Faulted transfer attributes as seen by the unit.
  typedef struct packed {
    logic        priv_fault;   // Access window violation, else bus error.
    logic        locked;
    logic        read;
    logic        misaligned;
    logic        line_fill;    // Fill from read miss.
    logic        push;         // Cache line push.
    logic        block_move;   // Line block move write.
    logic        ifetch;
    logic        supervisor;
    logic        pc_rel;       // PC-relative or alternate move to code space.
    logic [1:0]  size;
    logic [1:0]  orig_size;
    logic [1:0]  kind;
    logic [2:0]  modifier;
    logic [31:0] first_addr;
    logic [31:0] addr;
    logic        trace_pend;
    logic        mmove;
  } aefu_fault_t;

  // One pending write-back slot.
  typedef struct packed {
    logic        valid;
    logic [1:0]  size;
    logic [1:0]  kind;
    logic [2:0]  modifier;
    logic [31:0] addr;
    logic [31:0] data;
  } aefu_wb_t;

endpackage

// ==== core/aefu_align.sv ====
// Write-back data aligner: register aligned or memory lane aligned.
// Assumes data arrives register aligned in the low bits.
module aefu_align
  import aefu_pkg::*;
(
  // Data in
  input  wire logic [31:0] reg_data,
  input  wire logic [1:0]  size,
  input  wire logic [1:0]  low_addr,
  input  wire logic        mem_mode,
  // Data out
  output logic [31:0]      out_data
);

  logic [31:0] masked;
  logic [5:0]  rot;

  // Mask to the size; memory mode rotates left so byte 0 lands on its lane.
  always_comb
  begin
    case (size)
      AEFU_SZ_BYTE: masked = {24'h000000, reg_data[7:0]};
      AEFU_SZ_WORD: masked = {16'h0000, reg_data[15:0]};
      default:      masked = reg_data;
    endcase
    case (size)
      AEFU_SZ_BYTE: rot = 6'd24;
      AEFU_SZ_WORD: rot = 6'd16;
      default:      rot = 6'd0;
    endcase
    rot = rot - {1'b0, low_addr, 3'b000};
    if (mem_mode)
      out_data = (masked << rot[4:0]) | (masked >> (6'd32 - {1'b0, rot[4:0]}));
    else
      out_data = masked;
  end

endmodule

// ==== core/aefu_retchk.sv ====
// Return-from-exception frame check: decodes format and continuation bits.
// Assumes the saved halfword and format code are already read from the stack.
module aefu_retchk
  import aefu_pkg::*;
(
  // Frame contents
  input  wire logic [15:0] special_status_halfword,
  input  wire logic [3:0]  fmt,
  input  wire logic [3:0]  cont_extra,
  // Decision
  output aefu_ret_t        outcome
);

  logic [4:0] cont;
  logic [2:0] ones;

  // Count continuation bits; a lone one selects the continuation path.
  always_comb
  begin
    cont = {special_status_halfword[AEFU_SSW_CT], special_status_halfword[AEFU_SSW_CM], cont_extra[1:0], 1'b0};
    ones = 3'(cont[4]) + 3'(cont[3]) + 3'(cont[2]) + 3'(cont[1]);
    if (fmt != AEFU_FMT_ACCESS)
      outcome = AEFU_RET_FMTX;
    else if (ones > 3'd1)
      outcome = AEFU_RET_MULTI;
    else if (special_status_halfword[AEFU_SSW_CM])
      outcome = AEFU_RET_MMOVE;
    else if (ones == 3'd1)
      outcome = AEFU_RET_PEND;
    else
      outcome = AEFU_RET_RESUME;
  end

endmodule

// ==== core/aefu_core.sv ====
// Access error frame unit: captures faulted access state into frame fields
// and checks frames on return from exception.
// Assumes one core clock, classic Wishbone register port, fault inputs valid
// for the cycle of their strobe.
module aefu_core
  import aefu_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              clk_en,
  // Fault capture
  input  wire logic              fault_stb,
  input  wire logic              addr_err_stb,
  input  wire aefu_pkg::aefu_fault_t fault,
  input  wire aefu_pkg::aefu_wb_t    wb3_in,
  input  wire aefu_pkg::aefu_wb_t    wb2_in,
  input  wire aefu_pkg::aefu_wb_t    wb1_in,
  input  wire logic [127:0]      push_in,
  input  wire logic [31:0]       sp_in,
  // Return check
  input  wire logic              ret_stb,
  input  wire logic              ret_nested_fault,
  // Frame status outputs
  output logic                   frame_done,
  output logic [31:0]            sp_out,
  output logic                   short_frame,
  output logic                   restart_mmove,
  output logic                   take_pending,
  output logic                   format_exc,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o
);

  // ==========================================================================
  // Storage
  logic [15:0]  ssw_reg;
  logic [31:0]  eloc_reg;
  logic [7:0]   wbs_reg [3];
  logic [31:0]  wba_reg [3];
  logic [31:0]  wbd_reg [3];
  logic [31:0]  push_reg [4];
  logic [31:0]  eff_reg;
  logic [15:0]  rssw_reg;
  logic [7:0]   rfmt_reg;
  logic [1:0]   cext_reg;
  logic         enable_reg;
  aefu_ret_t    res_reg;
  logic [31:0]  wbd_next [3];
  aefu_ret_t    outcome;
  logic         bus_req;

  // Pack one write-back status byte.
  function automatic logic [7:0] aefu_wbs(input aefu_wb_t w);
    aefu_wbs = {w.valid, w.size, w.kind, w.modifier};
  endfunction

  // ==========================================================================
  // Alignment of write-back payloads
  aefu_align u_al3 (
    .reg_data (wb3_in.data),
    .size     (wb3_in.size),
    .low_addr (wb3_in.addr[1:0]),
    .mem_mode (1'b0),
    .out_data (wbd_next[0])
  );

  aefu_align u_al2 (
    .reg_data (wb2_in.data),
    .size     (wb2_in.size),
    .low_addr (wb2_in.addr[1:0]),
    .mem_mode (1'b0),
    .out_data (wbd_next[1])
  );

  aefu_align u_al1 (
    .reg_data (wb1_in.data),
    .size     (wb1_in.size),
    .low_addr (wb1_in.addr[1:0]),
    .mem_mode (1'b1),
    .out_data (wbd_next[2])
  );

  aefu_retchk u_ret (
    .special_status_halfword        (rssw_reg),
    .fmt        (rfmt_reg[7:4]),
    .cont_extra ({2'b00, cext_reg}),
    .outcome    (outcome)
  );

  // ==========================================================================
  // Status halfword capture
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      ssw_reg <= 16'h0000;
    else if (clk_en && enable_reg && fault_stb)
    begin
      ssw_reg <= 16'h0000;
      ssw_reg[AEFU_SSW_PRIV] <= fault.priv_fault;
      ssw_reg[AEFU_SSW_LOCK] <= fault.locked;
      ssw_reg[AEFU_SSW_RD]   <= fault.read;
      ssw_reg[AEFU_SSW_MIS]  <= fault.misaligned & fault.priv_fault;
      ssw_reg[AEFU_SSW_CT]   <= fault.trace_pend & ~fault.mmove;
      ssw_reg[AEFU_SSW_CM]   <= fault.mmove;
      if (fault.push)
        ssw_reg[AEFU_SSW_SZ +: 2] <= (fault.size == AEFU_SZ_LINE) ? AEFU_SZ_LINE
                                                                 : AEFU_SZ_LONG;
      else if (fault.line_fill)
        ssw_reg[AEFU_SSW_SZ +: 2] <= fault.orig_size;
      else
        ssw_reg[AEFU_SSW_SZ +: 2] <= fault.size;
      if (fault.push)
      begin
        ssw_reg[AEFU_SSW_KIND +: 2] <= AEFU_TT_NORM;
        ssw_reg[AEFU_SSW_MOD +: 3]  <= AEFU_TM_PUSH;
      end
      else if (fault.ifetch)
      begin
        ssw_reg[AEFU_SSW_KIND +: 2] <= fault.kind;
        ssw_reg[AEFU_SSW_MOD +: 3]  <= fault.supervisor ? AEFU_TM_SCODE
                                                        : AEFU_TM_UCODE;
      end
      else if (fault.pc_rel)
      begin
        ssw_reg[AEFU_SSW_KIND +: 2] <= fault.kind;
        ssw_reg[AEFU_SSW_MOD +: 3]  <= fault.supervisor ? AEFU_TM_SDATA
                                                        : AEFU_TM_UDATA;
      end
      else if (fault.read)
      begin
        ssw_reg[AEFU_SSW_KIND +: 2] <= AEFU_TT_NORM;
        ssw_reg[AEFU_SSW_MOD +: 3]  <= fault.modifier;
      end
      else
      begin
        ssw_reg[AEFU_SSW_KIND +: 2] <= fault.kind;
        ssw_reg[AEFU_SSW_MOD +: 3]  <= fault.modifier;
      end
    end
  end

  // Error location: first byte for misaligned, referenced address otherwise; an address error stores it with bit 0 cleared.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      eloc_reg <= 32'h0000_0000;
    else if (clk_en && enable_reg && fault_stb)
      eloc_reg <= fault.misaligned ? fault.first_addr : fault.addr;
    else if (clk_en && enable_reg && addr_err_stb)
      eloc_reg <= {fault.addr[31:1], 1'b0};
  end

  // ==========================================================================
  // Write-back slots: index 0 is slot three, 1 slot two, 2 slot one.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_slot
      always_ff @(posedge sys_clk or posedge rst)
      begin
        if (rst)
        begin
          wbs_reg[gi] <= 8'h00;
          wba_reg[gi] <= 32'h0000_0000;
          wbd_reg[gi] <= 32'h0000_0000;
        end
        else if (clk_en && enable_reg && fault_stb)
        begin
          wba_reg[gi] <= (gi == 0) ? wb3_in.addr : (gi == 1) ? wb2_in.addr
                                                            : wb1_in.addr;
          wbd_reg[gi] <= wbd_next[gi];
          if (fault.ifetch)
            wbs_reg[gi] <= 8'h00;
          else if (gi == 0)
            wbs_reg[gi] <= aefu_wbs(wb3_in);
          else if (gi == 1)
            wbs_reg[gi] <= fault.read ? 8'h00 : aefu_wbs(wb2_in);
          else if (fault.read || fault.push || fault.block_move)
            wbs_reg[gi] <= 8'h00;
          else
            wbs_reg[gi] <= aefu_wbs(wb1_in);
        end
      end
    end
  endgenerate

  // Push image words kept as they come from the line, already memory aligned.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      push_reg <= '{default: 32'h0000_0000};
    else if (clk_en && enable_reg && fault_stb)
      for (int i = 0; i < 4; i++)
        push_reg[i] <= push_in[32*i +: 32];
  end

  // Frame pointer and done pulse: frame grows downward on creation.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sp_out      <= 32'h0000_0000;
      frame_done  <= 1'b0;
      short_frame <= 1'b0;
    end
    else if (clk_en)
    begin
      frame_done <= 1'b0;
      if (enable_reg && fault_stb)
      begin
        sp_out      <= sp_in - AEFU_FRAME_BYTES;
        frame_done  <= 1'b1;
        short_frame <= 1'b0;
      end
      else if (enable_reg && addr_err_stb)
      begin
        sp_out      <= sp_in - AEFU_SHORT_BYTES;
        frame_done  <= 1'b1;
        short_frame <= 1'b1;
      end
      else if (ret_stb && (outcome == AEFU_RET_FMTX || ret_nested_fault))
        sp_out <= sp_in - AEFU_FRAME_BYTES;
      else if (ret_stb && outcome != AEFU_RET_MULTI)
        sp_out <= sp_in + AEFU_FRAME_BYTES;
    end
  end

  // Return decision flags, one-cycle pulses after each return request.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      restart_mmove <= 1'b0;
      take_pending  <= 1'b0;
      format_exc    <= 1'b0;
      res_reg       <= AEFU_RET_NONE;
      eff_reg       <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      restart_mmove <= ret_stb && !ret_nested_fault && outcome == AEFU_RET_MMOVE;
      take_pending  <= ret_stb && !ret_nested_fault && outcome == AEFU_RET_PEND;
      format_exc    <= ret_stb && outcome == AEFU_RET_FMTX;
      if (ret_stb)
        res_reg <= ret_nested_fault ? AEFU_RET_NEST : outcome;
      if (enable_reg && fault_stb)
        eff_reg <= fault.first_addr;
    end
  end

  // ==========================================================================
  // Wishbone slave: one wait state, ack dropped after one cycle.
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h0000_0000;
      enable_reg <= 1'b1;
      rssw_reg   <= 16'h0000;
      rfmt_reg   <= 8'h00;
      cext_reg   <= 2'b00;
    end
    else if (clk_en)
    begin
      wb_ack_o <= bus_req;
      if (bus_req && wb_we_i)
      begin
        case (wb_adr_i)
          AEFU_R_CTRL:
            if (wb_sel_i[0])
            begin
              enable_reg <= wb_dat_i[0];
              cext_reg   <= wb_dat_i[2:1];
            end
          AEFU_R_RSSW:
          begin
            if (wb_sel_i[0])
              rssw_reg[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
              rssw_reg[15:8] <= wb_dat_i[15:8];
          end
          AEFU_R_RFMT:
            if (wb_sel_i[0])
              rfmt_reg <= wb_dat_i[7:0];
          default: ;
        endcase
      end
      if (bus_req && !wb_we_i)
      begin
        case (wb_adr_i)
          AEFU_R_CTRL:  wb_dat_o <= {29'h0, cext_reg, enable_reg};
          AEFU_R_STAT:  wb_dat_o <= {29'h0, res_reg};
          AEFU_R_SSW:   wb_dat_o <= {16'h0000, ssw_reg};
          AEFU_R_ELOC:  wb_dat_o <= eloc_reg;
          AEFU_R_WBS:   wb_dat_o <= {8'h00, wbs_reg[2], wbs_reg[1], wbs_reg[0]};
          AEFU_R_RSSW:  wb_dat_o <= {16'h0000, rssw_reg};
          AEFU_R_RFMT:  wb_dat_o <= {24'h000000, rfmt_reg};
          AEFU_R_RES:   wb_dat_o <= eff_reg;
          8'h20:        wb_dat_o <= wba_reg[0];
          8'h24:        wb_dat_o <= wbd_reg[0];
          8'h28:        wb_dat_o <= wba_reg[1];
          8'h2c:        wb_dat_o <= wbd_reg[1];
          8'h30:        wb_dat_o <= wba_reg[2];
          8'h34:        wb_dat_o <= wbd_reg[2];
          8'h38:        wb_dat_o <= push_reg[0];
          8'h3c:        wb_dat_o <= push_reg[1];
          8'h40:        wb_dat_o <= push_reg[2];
          8'h44:        wb_dat_o <= push_reg[3];
          default:      wb_dat_o <= AEFU_UNMAPPED;
        endcase
      end
    end
  end

endmodule

// ==== verif/aefu_props.sv ====
// Checker for the access error frame unit: bus timing and frame outcomes.
// Assumes it is bound to aefu_core and sees only that module's ports.
module aefu_props
  import aefu_pkg::*;
(
  // Clock, reset and strobes
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        clk_en,
  input wire logic        fault_stb,
  input wire logic        addr_err_stb,
  input wire logic        ret_stb,
  input wire logic [31:0] sp_in,
  // Frame outputs
  input wire logic        frame_done,
  input wire logic [31:0] sp_out,
  input wire logic        short_frame,
  input wire logic        restart_mmove,
  input wire logic        take_pending,
  input wire logic        format_exc,
  // Bus handshake
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Assertions
  // All checks use the core clock and sleep while reset is high.
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  AST_ACK_LAT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o)
    else $error("bus request not answered in one cycle");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held for more than one cycle");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("acknowledge without a request");
  AST_RET_SINGLE: assert property ($onehot0({restart_mmove, take_pending, format_exc}))
    else $error("more than one return outcome at once");
  AST_MMOVE_POP: assert property (
    restart_mmove |-> $past(ret_stb) && sp_out == $past(sp_in) + AEFU_FRAME_BYTES)
    else $error("restart without a thirty word pop");
  AST_PEND_POP: assert property (
    take_pending |-> $past(ret_stb) && sp_out == $past(sp_in) + AEFU_FRAME_BYTES)
    else $error("pending exception without a thirty word pop");
  AST_FMT_BELOW: assert property (
    format_exc |-> $past(ret_stb) && sp_out == $past(sp_in) - AEFU_FRAME_BYTES)
    else $error("format exception frame not placed below");
  AST_FULL_FRAME: assert property (
    frame_done && $past(fault_stb) |-> sp_out == $past(sp_in) - AEFU_FRAME_BYTES)
    else $error("full frame size wrong");
  AST_SHORT_FRAME: assert property (
    $past(addr_err_stb && !fault_stb && clk_en) |->
      short_frame && sp_out == $past(sp_in) - AEFU_SHORT_BYTES)
    else $error("short frame missing or wrong size");
  AST_DONE_CAUSE: assert property (
    frame_done |-> $past(fault_stb || addr_err_stb) && $past(clk_en))
    else $error("frame done without a fault");

  // Main scenarios reached.
  COV_FRAME: cover property (frame_done);
  COV_MMOVE: cover property (restart_mmove);
  COV_FMT: cover property (format_exc);
endmodule

bind aefu_core aefu_props aefu_props_inst (
  .sys_clk, .rst, .clk_en, .fault_stb, .addr_err_stb, .ret_stb, .sp_in,
  .frame_done, .sp_out, .short_frame, .restart_mmove, .take_pending, .format_exc,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o
);

// ==== verif/aefu_tb.sv ====
// Testbench for the access error frame unit: faults, returns, register reads.
// Assumes the package and aefu_core are compiled first; one 200 MHz clock.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import aefu_pkg::*;

  // ==========================================================================
  // Signals
  logic         sys_clk = 1'b0;
  logic         rst, clk_en, fault_stb, addr_err_stb, ret_stb, ret_nested_fault;
  aefu_fault_t  fault;
  aefu_wb_t     wb1_in, wb2_in, wb3_in;
  logic [127:0] push_in;
  logic [31:0]  sp_in, sp_out, exp_sp, wb_dat, wb_dat_o;
  logic [15:0]  last_ssw;
  logic         frame_done, short_frame, restart_mmove, take_pending, format_exc;
  logic         wb_cyc, wb_stb, wb_we, wb_ack_o, ev_d;
  logic [7:0]   wb_adr;
  logic [3:0]   wb_sel, sel_v;
  logic [31:0]  rd_q[$], sp_q[$];
  int           mismatches, num_checks;

  // Clock of 5 ns period.
  always #2.5 sys_clk = ~sys_clk;

  aefu_core aefu_core_inst (
    .sys_clk, .rst, .clk_en, .fault_stb, .addr_err_stb, .fault, .wb3_in, .wb2_in,
    .wb1_in, .push_in, .sp_in, .ret_stb, .ret_nested_fault, .frame_done, .sp_out,
    .short_frame, .restart_mmove, .take_pending, .format_exc, .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_dat_o, .wb_ack_o
  );

  // ==========================================================================
  // Checking
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One compare task for each kind of result.
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    chk(got, exp, "read data");
  endtask

  task automatic chk_sp(input logic [31:0] got, input logic [31:0] exp);
    chk(got, exp, "stack pointer");
  endtask

  // Takes the oldest note whenever read data or a new stack pointer appears.
  always @(posedge sys_clk)
  begin
    if (wb_ack_o === 1'b1 && !wb_we && rd_q.size() > 0)
      chk_rd(wb_dat_o, rd_q.pop_front());
    if (ev_d && sp_q.size() > 0)
      chk_sp(sp_out, sp_q.pop_front());
    ev_d = (fault_stb | addr_err_stb | ret_stb) & clk_en & !rst;
  end

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================================
  // Drivers
  // One classic bus cycle; the request is held until acknowledge is sampled.
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge sys_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= adr;
    wb_sel <= sel_v;
    wb_dat <= dat;
    do
      @(posedge sys_clk);
    while (wb_ack_o !== 1'b1);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    bus(1'b1, adr, dat);
  endtask

  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    rd_q.push_back(exp);
    bus(1'b0, adr, 32'h0);
  endtask

  // One-cycle strobe: 0 fault, 1 address error, 2 return.
  task automatic strobe(input int k, input logic [31:0] sp, input logic [31:0] e);
    @(posedge sys_clk);
    sp_in        <= sp;
    fault_stb    <= (k == 0);
    addr_err_stb <= (k == 1);
    ret_stb      <= (k == 2);
    sp_q.push_back(e);
    @(posedge sys_clk);
    fault_stb    <= 1'b0;
    addr_err_stb <= 1'b0;
    ret_stb      <= 1'b0;
  endtask

  // Classes: 0 read fill, 1 write, 2 push, 3 fetch, 4 misaligned window, 5 block move.
  task automatic do_fault(input int c, input logic en);
    aefu_fault_t  f;
    aefu_wb_t     w[3];
    logic [7:0]   s[3];
    logic [127:0] p;
    logic [63:0]  dd;
    logic [31:0]  sp;
    int           i, r;
    f = '0;
    f.addr = $urandom;
    f.first_addr = f.addr - ($urandom % 3);
    f.supervisor = 1'($urandom);
    f.read = (c == 0);
    f.locked = (c < 2) && 1'($urandom);
    f.line_fill = (c == 0);
    f.push = (c == 2);
    f.ifetch = (c == 3);
    f.priv_fault = (c == 4);
    f.misaligned = (c == 4);
    f.block_move = (c == 5);
    f.pc_rel = (c == 0);
    f.size = (c == 0) ? 2'h3 : (c == 2) ? {2{1'($urandom)}} : 2'($urandom % 3);
    f.orig_size = (c == 0) ? 2'($urandom % 3) : f.size;
    f.kind = (c == 5) ? 2'h1 : 2'h0;
    f.modifier = (c == 2) ? 3'h0 : {f.supervisor, c == 3 || c == 0, c != 3 && c != 0};
    f.mmove = (c != 3) && 1'($urandom);
    f.trace_pend = (c != 3) && 1'($urandom);
    p = {$urandom, $urandom, $urandom, $urandom};
    sp = $urandom & 32'hffff_fffc;
    for (i = 0; i < 3; i++)
    begin
      w[i] = '0;
      w[i].valid = 1'b1;
      w[i].size = 2'($urandom % 3);
      w[i].modifier = {f.supervisor, 2'b01};
      w[i].addr = $urandom;
      w[i].data = $urandom >> ((w[i].size == 2'h1) ? 24 : (w[i].size == 2'h2) ? 16 : 0);
      s[i] = {1'b1, w[i].size, w[i].kind, w[i].modifier};
    end
    if (c == 4)
      w[0] = '0;
    s[0] = (c == 1) ? s[0] : 8'h00;
    s[1] = (c == 0 || c == 3) ? 8'h00 : s[1];
    s[2] = (c == 3) ? 8'h00 : s[2];
    fault   <= f;
    wb1_in  <= w[0];
    wb2_in  <= w[1];
    wb3_in  <= w[2];
    push_in <= p;
    exp_sp = en ? sp - AEFU_FRAME_BYTES : exp_sp;
    strobe(0, sp, exp_sp);
    if (en)
      last_ssw = {2'b00, f.trace_pend & !f.mmove, f.mmove, f.misaligned, f.priv_fault,
                  f.locked, f.read, 1'b0, f.orig_size, f.kind,
                  (f.pc_rel ? {f.supervisor, 2'b01} : f.modifier)};
    rd(AEFU_R_SSW, {16'h0, last_ssw});
    if (en)
    begin
      rd(AEFU_R_ELOC, f.misaligned ? f.first_addr : f.addr);
      rd(AEFU_R_WBS, {8'h00, s[0], s[1], s[2]});
      for (i = 0; i < 3; i++)
      begin
        r = (64 - 8 * ((w[i].size == 2'h1) ? 1 : (w[i].size == 2'h2) ? 2 : 4)
             - 8 * w[i].addr[1:0]) % 32;
        dd = {w[i].data, w[i].data} << r;
        if (s[i][7])
        begin
          rd(8'h30 - 8'(8 * i), w[i].addr);
          rd(8'h34 - 8'(8 * i), (i == 0) ? dd[63:32] : w[i].data);
        end
      end
      for (i = 0; i < 4; i++)
        rd(AEFU_R_PUSH + 8'(4 * i), p[32 * i +: 32]);
    end
  endtask

  // Loads a frame for return, fires the return and checks outcome and pointer.
  task automatic do_ret(input logic [15:0] h, input logic [3:0] fm, input logic [1:0] x,
                        input logic nf, input aefu_ret_t o);
    logic [31:0] sp;
    sp = $urandom & 32'hffff_fffc;
    wr(AEFU_R_RSSW, {16'h0, h});
    wr(AEFU_R_RFMT, {24'h0, fm, 4'h0});
    wr(AEFU_R_CTRL, {29'h0, x, 1'b1});
    ret_nested_fault <= nf;
    exp_sp = (o == AEFU_RET_MULTI) ? exp_sp :
             (o == AEFU_RET_FMTX || o == AEFU_RET_NEST) ? sp - AEFU_FRAME_BYTES :
             sp + AEFU_FRAME_BYTES;
    strobe(2, sp, exp_sp);
    rd(AEFU_R_STAT, {29'h0, o});
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    int k;
    {rst, clk_en, ev_d} = 3'b110;
    {fault_stb, addr_err_stb, ret_stb, ret_nested_fault} = 4'h0;
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} = '0;
    {wb_sel, sel_v} = 8'h0f;
    {fault, wb1_in, wb2_in, wb3_in, push_in, sp_in} = '0;
    {exp_sp, last_ssw, mismatches, num_checks} = '0;
    void'($urandom(21131));
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    rd(AEFU_R_CTRL, 32'h1);
    rd(AEFU_R_STAT, 32'h0);
    rd(AEFU_R_SSW, 32'h0);
    rd(8'h48, 32'h0);
    for (k = 0; k < 24; k++)
      do_fault(k % 6, 1'b1);
    wr(AEFU_R_CTRL, 32'h0);
    do_fault(1, 1'b0);
    wr(AEFU_R_CTRL, 32'h1);
    fault.addr <= $urandom | 32'h1;
    exp_sp = sp_out - AEFU_SHORT_BYTES;
    strobe(1, sp_out, exp_sp);
    rd(AEFU_R_ELOC, fault.addr & 32'hffff_fffe);
    clk_en <= 1'b0;
    fork
      rd(AEFU_R_CTRL, 32'h1);
      begin
        repeat (4) @(posedge sys_clk);
        clk_en <= 1'b1;
      end
    join
    do_ret(16'h0000, 4'h7, 2'b00, 1'b0, AEFU_RET_RESUME);
    do_ret(16'h1000, 4'h7, 2'b00, 1'b0, AEFU_RET_MMOVE);
    do_ret(16'h2000, 4'h7, 2'b00, 1'b0, AEFU_RET_PEND);
    do_ret(16'h0000, 4'h7, 2'b01, 1'b0, AEFU_RET_PEND);
    do_ret(16'h0000, 4'h7, 2'b10, 1'b0, AEFU_RET_PEND);
    do_ret(16'h3000, 4'h7, 2'b00, 1'b0, AEFU_RET_MULTI);
    do_ret(16'h0000, 4'hf, 2'b00, 1'b0, AEFU_RET_FMTX);
    do_ret(16'h0000, 4'h7, 2'b00, 1'b1, AEFU_RET_NEST);
    wr(AEFU_R_STAT, 32'hffff_ffff);
    rd(AEFU_R_STAT, {29'h0, AEFU_RET_NEST});
    sel_v = 4'h2;
    wr(AEFU_R_RSSW, 32'h1234_ab56);
    sel_v = 4'hf;
    rd(AEFU_R_RSSW, 32'h0000_ab00);
    repeat (3) @(posedge sys_clk);
    give_verdict();
  end

  // Watchdog: the sequence needs about a thousand cycles; 20000 is ample.
  initial
  begin
    #100000;
    mismatches++;
    give_verdict();
  end
endmodule
